// ---- hw/edc_pkg.sv ----
// Package of constants for the extended-output page DRAM host-side cycle controller.
// Assumes a 100 MHz single clock and one external 1M x 16 EDO DRAM.
// How it works
// - Early write: write strobe low before column strobes fall.
// - Page mode: row strobe stays low, only new columns on later strobes.
// - Host issues 1,024 refresh cycles every 16 ms.
// - Row-only cycles with column strobes high serve as the initialization dummy cycles.
// - Strobe-order refresh: column strobe low before row strobe falls, write high.
// - Host completes initialization before any access or refresh.
// - Row address presented at row strobe fall, column at column strobe fall.
package edc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RAS_SETUP_NS = 50;   // Row access time
    localparam int T_CAS_NS = 30;         // Page cycle
    localparam int T_PRE_NS = 30;         // Precharge
    localparam int T_INIT_US = 200;
    localparam int REFRESH_ROWS = 1024;
    localparam int REFRESH_MS = 16;
    localparam int INIT_CYCLES = 8;
    localparam int CYC_RAS = (T_RAS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CAS = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PRE = (T_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_INIT = T_INIT_US * 1000 / CLK_PERIOD_NS;
    // Longest time between refreshes rounds down
    localparam int CYC_REFI = REFRESH_MS * 1000000 / CLK_PERIOD_NS / REFRESH_ROWS;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam logic [1:0] BYTE_LO = 2'h1;
    localparam logic [1:0] BYTE_HI = 2'h2;
    localparam logic [1:0] BYTE_ALL = 2'h3;
    typedef enum logic [3:0] {
        ST_INIT   = 4'h0,
        ST_INITRF = 4'h1,
        ST_IDLE   = 4'h2,
        ST_ROW    = 4'h3,
        ST_COL    = 4'h4,
        ST_COLEND = 4'h5,
        ST_PRE    = 4'h6,
        ST_RFCAS  = 4'h7,
        ST_RFRAS  = 4'h8
    } edc_state_t;
endpackage

// ---- hw/edc_timer.sv ----
// Down-counting delay timer with a busy flag held high while the count is nonzero.
// Assumes load and value come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module edc_timer
    import edc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] value,
    output logic                  busy
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = value;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - CNT_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign busy = (cnt_r != '0);
endmodule
`default_nettype wire

// ---- hw/edc_ctrl.sv ----
// Host-side controller for a 1M x 16 extended-output page DRAM: sequences strobes by clock.
// Assumes a user request port on CLK and the DRAM wired to the pin outputs.
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl
    import edc_pkg::*;
#(
    parameter int INIT_WAIT = CYC_INIT,
    parameter int REFI_WAIT = CYC_REFI
)
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              REQ_VALID,
    input  wire logic              REQ_WRITE,
    input  wire logic [1:0]        REQ_BYTE,
    input  wire logic [19:0]       REQ_ADDR,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    output logic                   REQ_READY,
    output logic                   RD_VALID,
    output logic [DATA_W-1:0]      RD_DATA,
    output logic                   INIT_DONE,
    output logic                   ROW_STROBE_N,
    output logic                   LOWER_COL_STROBE_N,
    output logic                   UPPER_COL_STROBE_N,
    output logic                   WRITE_STROBE_N,
    output logic                   OUT_GATE_N,
    output logic [ADDR_W-1:0]      MUX_ADDR,
    input  wire logic [DATA_W-1:0] DATA_PINS_I,
    output logic [DATA_W-1:0]      DATA_PINS_O,
    output logic [DATA_W-1:0]      DATA_PINS_OE
);
    // ****************************************************************
    // State
    // ****************************************************************
    edc_state_t        st_r, st_nxt;
    logic [ADDR_W-1:0] row_r, row_nxt, col_r, col_nxt;
    logic              wr_r, wr_nxt;
    logic [1:0]        be_r, be_nxt;
    logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic              rdv_r, rdv_nxt, rdy_r, rdy_nxt, done_r, done_nxt;
    logic              ras_r, ras_nxt, lo_cs_r, lo_cs_nxt, up_cs_r, up_cs_nxt;
    logic              we_r, we_nxt, oe_r, oe_nxt, doe_r, doe_nxt;
    logic [ADDR_W-1:0] ma_r, ma_nxt;
    logic [3:0]        ini_r, ini_nxt;
    logic [31:0]       refi_r, refi_nxt;
    logic              rf_pend_r, rf_pend_nxt;
    logic              refi_wrap;
    logic              tload;
    logic [CNT_W-1:0]  tval;
    logic              tbusy;
    logic [DATA_W-1:0] din_s1_r, din_s2_r;

    // Data pins come from outside the clock domain
    always_ff @(posedge CLK)
    begin
        din_s1_r <= DATA_PINS_I;
        din_s2_r <= din_s1_r;
    end

    edc_timer u_tmr (
        .clk   (CLK),
        .rst_n (RST_N),
        .load  (tload),
        .value (tval),
        .busy  (tbusy)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        row_nxt = row_r;
        col_nxt = col_r;
        wr_nxt = wr_r;
        be_nxt = be_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        rdv_nxt = 1'b0;
        rdy_nxt = 1'b0;
        done_nxt = done_r;
        ras_nxt = ras_r;
        lo_cs_nxt = lo_cs_r;
        up_cs_nxt = up_cs_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        doe_nxt = doe_r;
        ma_nxt = ma_r;
        ini_nxt = ini_r;
        tload = 1'b0;
        tval = '0;
        rf_pend_nxt = rf_pend_r;
        refi_nxt = refi_r + 32'h1;
        refi_wrap = (refi_r >= 32'(REFI_WAIT - 1));
        if (refi_wrap)
        begin
            refi_nxt = '0;
            rf_pend_nxt = done_r;
        end
        case (st_r)
            ST_INIT:
            begin
                // Pause, then eight dummy row cycles before any access
                if (refi_r >= 32'(INIT_WAIT - 1))
                begin
                    st_nxt = ST_INITRF;
                    refi_nxt = '0;
                end
            end
            ST_INITRF:
            begin
                if (!tbusy)
                begin
                    if (ras_r)
                    begin
                        ras_nxt = 1'b0;  // Row-only cycle, strobes high
                        tload = 1'b1;
                        tval = cyc(CYC_RAS);
                    end
                    else
                    begin
                        ras_nxt = 1'b1;
                        tload = 1'b1;
                        tval = cyc(CYC_PRE);
                        ini_nxt = ini_r + 4'h1;
                        if (ini_r == 4'(INIT_CYCLES - 1))
                        begin
                            done_nxt = 1'b1;
                            // Last precharge must end before the first access
                            st_nxt = ST_PRE;
                        end
                    end
                end
            end
            ST_IDLE:
            begin
                rdy_nxt = !rf_pend_nxt;
                if (rf_pend_r && !tbusy)
                begin
                    // Column strobes fall first, write high
                    rdy_nxt = 1'b0;
                    lo_cs_nxt = 1'b0;
                    up_cs_nxt = 1'b0;
                    we_nxt = 1'b1;
                    // An interval ending now stays pending: the set wins
                    rf_pend_nxt = refi_wrap;
                    tload = 1'b1;
                    tval = cyc(1);
                    st_nxt = ST_RFCAS;
                end
                else if (REQ_VALID && rdy_r)
                begin
                    rdy_nxt = 1'b0;
                    row_nxt = REQ_ADDR[19:10];
                    col_nxt = REQ_ADDR[9:0];
                    wr_nxt = REQ_WRITE;
                    be_nxt = (REQ_BYTE == 2'h0) ? BYTE_ALL : REQ_BYTE;
                    wd_nxt = REQ_WDATA;
                    ma_nxt = REQ_ADDR[19:10];  // Row first
                    st_nxt = ST_ROW;
                end
            end
            ST_ROW:
            begin
                ras_nxt = 1'b0;
                tload = 1'b1;
                tval = cyc(CYC_RAS);
                st_nxt = ST_COL;
            end
            ST_COL:
            begin
                // Address, write strobe and data settle a cycle ahead of the column
                // fall, so neither the row latch nor the strobe edge sees them move
                ma_nxt = col_r;  // Column after row fall
                we_nxt = !wr_r;  // Early write
                oe_nxt = wr_r;  // Gate low only for reads
                doe_nxt = wr_r;  // Drive pins only when writing
                if (!tbusy)
                begin
                    lo_cs_nxt = !be_r[0];  // Bits 0-7
                    up_cs_nxt = !be_r[1];  // Bits 8-15
                    tload = 1'b1;
                    tval = cyc(CYC_CAS + 2);
                    st_nxt = ST_COLEND;
                end
            end
            ST_COLEND:
            begin
                if (!tbusy)
                begin
                    if (!wr_r)
                    begin
                        rdv_nxt = 1'b1;
                        rd_nxt = {be_r[1] ? din_s2_r[15:8] : 8'h00,
                                  be_r[0] ? din_s2_r[7:0] : 8'h00};
                    end
                    lo_cs_nxt = 1'b1;
                    up_cs_nxt = 1'b1;
                    // Next access in same row keeps row strobe low
                    if (REQ_VALID && !rf_pend_r && REQ_ADDR[19:10] == row_r)
                    begin
                        col_nxt = REQ_ADDR[9:0];
                        ma_nxt = REQ_ADDR[9:0];
                        wr_nxt = REQ_WRITE;
                        be_nxt = (REQ_BYTE == 2'h0) ? BYTE_ALL : REQ_BYTE;
                        wd_nxt = REQ_WDATA;
                        tload = 1'b1;
                        tval = cyc(CYC_PRE);
                        st_nxt = ST_COL;
                    end
                    else
                    begin
                        ras_nxt = 1'b1;
                        we_nxt = 1'b1;
                        oe_nxt = 1'b1;
                        doe_nxt = 1'b0;
                        tload = 1'b1;
                        tval = cyc(CYC_PRE);
                        st_nxt = ST_PRE;
                    end
                end
            end
            ST_PRE:
            begin
                we_nxt = 1'b1;
                oe_nxt = 1'b1;
                doe_nxt = 1'b0;
                if (!tbusy)
                begin
                    st_nxt = ST_IDLE;
                    rdy_nxt = !rf_pend_nxt;
                end
            end
            ST_RFCAS:
            begin
                if (!tbusy)
                begin
                    ras_nxt = 1'b0;  // Row falls with column low
                    tload = 1'b1;
                    tval = cyc(CYC_RAS);
                    st_nxt = ST_RFRAS;
                end
            end
            ST_RFRAS:
            begin
                if (!tbusy)
                begin
                    ras_nxt = 1'b1;
                    lo_cs_nxt = 1'b1;
                    up_cs_nxt = 1'b1;
                    tload = 1'b1;
                    tval = cyc(CYC_PRE);
                    st_nxt = ST_PRE;
                end
            end
            default:
                st_nxt = ST_INIT;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st_r <= ST_INIT;
            row_r <= '0;
            col_r <= '0;
            wr_r <= 1'b0;
            be_r <= BYTE_ALL;
            wd_r <= '0;
            rd_r <= '0;
            rdv_r <= 1'b0;
            rdy_r <= 1'b0;
            done_r <= 1'b0;
            ras_r <= 1'b1;
            lo_cs_r <= 1'b1;
            up_cs_r <= 1'b1;
            we_r <= 1'b1;
            oe_r <= 1'b1;
            doe_r <= 1'b0;
            ma_r <= '0;
            ini_r <= '0;
            refi_r <= '0;
            rf_pend_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            row_r <= row_nxt;
            col_r <= col_nxt;
            wr_r <= wr_nxt;
            be_r <= be_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            rdv_r <= rdv_nxt;
            rdy_r <= rdy_nxt;
            done_r <= done_nxt;
            ras_r <= ras_nxt;
            lo_cs_r <= lo_cs_nxt;
            up_cs_r <= up_cs_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            doe_r <= doe_nxt;
            ma_r <= ma_nxt;
            ini_r <= ini_nxt;
            refi_r <= refi_nxt;
            rf_pend_r <= rf_pend_nxt;
        end
    end

    assign REQ_READY = rdy_r;
    assign RD_VALID = rdv_r;
    assign RD_DATA = rd_r;
    assign INIT_DONE = done_r;
    assign ROW_STROBE_N = ras_r;
    assign LOWER_COL_STROBE_N = lo_cs_r;
    assign UPPER_COL_STROBE_N = up_cs_r;
    assign WRITE_STROBE_N = we_r;
    assign OUT_GATE_N = oe_r;
    assign MUX_ADDR = ma_r;
    assign DATA_PINS_O = wd_r;
    assign DATA_PINS_OE = {DATA_W{doe_r}};

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Refresh lowers the column strobes with the row strobe high, so it is left out here
    AST_EARLY_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
        !ras_r && ($fell(lo_cs_r) || $fell(up_cs_r)) && wr_r
            |-> !we_r && doe_r && !$past(we_r) && $past(doe_r))
        else $error("Column strobe fell without early write setup");
    AST_STROBE_ORDER_REFRESH: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(ras_r) && st_r == ST_RFRAS |-> !lo_cs_r && !up_cs_r && we_r)
        else $error("Strobe-order refresh out of order");
    AST_NO_ACCESS_BEFORE_INIT: assert property (@(posedge CLK) disable iff (!RST_N)
        !done_r |-> lo_cs_r && up_cs_r && !doe_r)
        else $error("Column access before initialization");
    AST_NO_DRIVE_ON_READ: assert property (@(posedge CLK) disable iff (!RST_N)
        !oe_r |-> !doe_r && we_r)
        else $error("Host drives pins while gate is low");
    AST_BYTE_LANES: assert property (@(posedge CLK) disable iff (!RST_N)
        !ras_r && ($fell(lo_cs_r) || $fell(up_cs_r))
            |-> lo_cs_r == !be_r[0] && up_cs_r == !be_r[1])
        else $error("Column strobes disagree with byte select");
    AST_REFRESH_DUE: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(rf_pend_r) |-> ##[1:40] st_r == ST_RFCAS)
        else $error("Refresh not started in time");
endmodule
`default_nettype wire

// ---- sim/edc_dram_model.sv ----
// Behavioural model of the 1M x 16 extended-output page DRAM on the host's pins.
// Assumes the bench resolves the shared data pins from both sides' drive enables.
`timescale 1ns/1ps
`default_nettype none
module edc_dram_model
    import edc_pkg::*;
(
    input  wire logic              ras_n,
    input  wire logic              lower_col_strobe_n,
    input  wire logic              upper_col_strobe_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_drive,
    output logic      [15:0]       ras_cycles,
    output logic      [15:0]       refreshes,
    output logic      [15:0]       early,
    output logic      [15:0]       faults
);
    // ********
    // Storage
    // ********
    // No clock: storage and counters react to strobe edges, the pin drive also to write and gate levels
    logic [DATA_W-1:0] mem [int];   // Sparse and never decays
    logic [ADDR_W-1:0] row_r;
    logic [DATA_W-1:0] rd_word;
    logic [1:0]        lane_rd;
    logic [1:0]        valid;
    logic [1:0]        on;

    initial
    begin
        ras_cycles = 16'h0;
        refreshes = 16'h0;
        early = 16'h0;
        faults = 16'h0;
        lane_rd = 2'h0;
        valid = 2'h0;
        rd_word = 16'h0;
        row_r = 10'h0;
    end

    // ********
    // Data pins
    // ********
    // A lane drives only when read-selected; the output gate has no say in writes
    assign on = lane_rd & {2{we_n & ~oe_n}}
              & ~({2{ras_n}} & {upper_col_strobe_n, lower_col_strobe_n});
    assign dq_drive = {{8{on[1]}}, {8{on[0]}}};
    // Before access time, and when released, the pins show the inverse of the data
    assign dq_out = ({{8{valid[1]}}, {8{valid[0]}}} & rd_word)
                  | ({{8{~valid[1]}}, {8{~valid[0]}}} & ~rd_word);

    // ********
    // Strobes
    // ********
    always @(negedge ras_n)
    begin
        ras_cycles = ras_cycles + 16'h1;
        if (!lower_col_strobe_n || !upper_col_strobe_n)
        begin
            // Address ignored; always counts as refresh, and also as a fault unless the write strobe is high
            refreshes = refreshes + 16'h1;
            if (we_n !== 1'b1)
                faults = faults + 16'h1;
        end
        else
            row_r = addr;
    end

    always @(posedge ras_n)
        lane_rd = 2'h0;

    task automatic col_fall(input int hi);
        int          k;
        logic [15:0] w;
        if (ras_n !== 1'b0)
            return;
        k = {row_r, addr};                   // Row kept open across page columns
        if (ras_cycles < 16'h8)
            early = early + 16'h1;
        lane_rd[hi] = we_n;
        valid[hi] = 1'b0;
        #1;
        w = mem.exists(k) ? mem[k] : 16'h0;
        if (we_n === 1'b0)
        begin
            w[hi*8+:8] = dq_in[hi*8+:8];
            mem[k] = w;
        end
        else
        begin
            #13;
            rd_word[hi*8+:8] = w[hi*8+:8];
            valid[hi] = 1'b1;
        end
    endtask

    always @(negedge lower_col_strobe_n)
        col_fall(0);
    always @(negedge upper_col_strobe_n)
        col_fall(1);
endmodule
`default_nettype wire

// ---- sim/test_edo_dram_cycle_decoder.sv ----
// Self-checking bench for the host-side extended-output page DRAM controller.
// Assumes edc_pkg, edc_ctrl and the DRAM model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module test_edo_dram_cycle_decoder
    import edc_pkg::*;
;
    localparam int INIT_W = 20;
    localparam int REFI_W = 200;
    localparam int LIMIT  = 20000;

    logic              CLK;
    logic              RST_N;
    logic              REQ_VALID;
    logic              REQ_WRITE;
    logic [1:0]        REQ_BYTE;
    logic [19:0]       REQ_ADDR;
    logic [15:0]       REQ_WDATA;
    logic              REQ_READY;
    logic              RD_VALID;
    logic [15:0]       RD_DATA;
    logic              INIT_DONE;
    logic              ROW_STROBE_N;
    logic              LOWER_COL_STROBE_N;
    logic              UPPER_COL_STROBE_N;
    logic              WRITE_STROBE_N;
    logic              OUT_GATE_N;
    logic [ADDR_W-1:0] MUX_ADDR;
    logic [15:0]       dq_in;
    logic [15:0]       DATA_PINS_O;
    logic [15:0]       DATA_PINS_OE;
    logic [15:0]       dq_out;
    logic [15:0]       dq_drive;
    logic [15:0]       ras_cycles;
    logic [15:0]       refreshes;
    logic [15:0]       early;
    logic [15:0]       faults;
    int                bad_count;
    int                compares;
    int                cycles;

    // Shared pins: the host wins where it drives, the device elsewhere; a lane
    // nobody drives shows the inverse, so a sample taken while floating is caught
    assign dq_in = (DATA_PINS_OE & DATA_PINS_O) | (~DATA_PINS_OE & dq_drive & dq_out)
                 | (~DATA_PINS_OE & ~dq_drive & ~dq_out);

    edc_ctrl #(.INIT_WAIT(INIT_W), .REFI_WAIT(REFI_W)) u_edc_ctrl (
        .CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
        .REQ_BYTE(REQ_BYTE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
        .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
        .INIT_DONE(INIT_DONE), .ROW_STROBE_N(ROW_STROBE_N),
        .LOWER_COL_STROBE_N(LOWER_COL_STROBE_N), .UPPER_COL_STROBE_N(UPPER_COL_STROBE_N),
        .WRITE_STROBE_N(WRITE_STROBE_N), .OUT_GATE_N(OUT_GATE_N), .MUX_ADDR(MUX_ADDR),
        .DATA_PINS_I(dq_in), .DATA_PINS_O(DATA_PINS_O), .DATA_PINS_OE(DATA_PINS_OE));

    edc_dram_model u_edc_dram_model (
        .ras_n(ROW_STROBE_N), .lower_col_strobe_n(LOWER_COL_STROBE_N),
        .upper_col_strobe_n(UPPER_COL_STROBE_N),
        .we_n(WRITE_STROBE_N), .oe_n(OUT_GATE_N), .addr(MUX_ADDR), .dq_in(dq_in),
        .dq_out(dq_out), .dq_drive(dq_drive), .ras_cycles(ras_cycles),
        .refreshes(refreshes), .early(early), .faults(faults));

    // ********
    // Helpers
    // ********
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ge(input logic [15:0] got, input logic [15:0] lim);
        compares++;
        if (!(got >= lim))
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h min=%h", $time, got, lim);
        end
    endtask

    task automatic tick();
        @(posedge CLK);
        #1;
    endtask

    task automatic wait_init();
        int n;
        n = 0;
        while (INIT_DONE !== 1'b1 && n < 2000)
        begin
            tick();
            n++;
        end
    endtask

    // Holds the request until an edge takes it: ready seen high before it, or a
    // page hit, where the column strobes rise at it while the row strobe stays low
    task automatic do_req(input logic wr, input logic [1:0] be, input logic [19:0] a,
                          input logic [15:0] d, output logic [15:0] rd);
        int   n;
        logic rdy;
        logic pg;
        logic taken;
        REQ_VALID = 1'b1;
        REQ_WRITE = wr;
        REQ_BYTE = be;
        REQ_ADDR = a;
        REQ_WDATA = d;
        rd = 16'hFFFF;
        n = 0;
        taken = 1'b0;
        while (!taken && n < 400)
        begin
            rdy = (REQ_READY === 1'b1);
            pg = (ROW_STROBE_N === 1'b0) && !(LOWER_COL_STROBE_N && UPPER_COL_STROBE_N);
            tick();
            n++;
            taken = rdy || (pg && ROW_STROBE_N === 1'b0 && LOWER_COL_STROBE_N === 1'b1
                            && UPPER_COL_STROBE_N === 1'b1);
        end
        if (!taken)
            bad_count++;
        REQ_VALID = 1'b0;
        // One edge passes, which also lets an older read pulse go by
        tick();
        n = 0;
        while (!wr && RD_VALID !== 1'b1 && n < 60)
        begin
            tick();
            n++;
        end
        if (!wr)
            rd = RD_DATA;
    endtask

    task automatic wr(input logic [1:0] be, input logic [19:0] a, input logic [15:0] d);
        logic [15:0] r;
        do_req(1'b1, be, a, d, r);
    endtask

    task automatic rd_chk(input logic [1:0] be, input logic [19:0] a, input logic [15:0] e);
        logic [15:0] r;
        do_req(1'b0, be, a, 16'h0, r);
        chk_data(r, e);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_init();
        wait_init();
        chk_ge(ras_cycles, 16'h8);
        chk_data(early, 16'h0);
        chk_data(dq_drive | DATA_PINS_OE, 16'h0);
    endtask

    task automatic t_words();
        logic [19:0] at [3] = '{20'h00000, 20'hFFFFF, 20'h3FC01};
        for (int i = 0; i < 3; i++)
            wr(BYTE_ALL, at[i], 16'hA000 ^ at[i][15:0]);
        for (int i = 0; i < 3; i++)
            rd_chk(BYTE_ALL, at[i], 16'hA000 ^ at[i][15:0]);
    endtask

    task automatic t_bytes();
        wr(BYTE_ALL, 20'h12345, 16'h1234);
        wr(BYTE_LO, 20'h12345, 16'h55AB);
        rd_chk(BYTE_ALL, 20'h12345, 16'h12AB);
        wr(BYTE_HI, 20'h12345, 16'hCD77);
        rd_chk(2'h0, 20'h12345, 16'hCDAB);
        rd_chk(BYTE_LO, 20'h12345, 16'h00AB);
        rd_chk(BYTE_HI, 20'h12345, 16'hCD00);
    endtask

    task automatic t_page();
        wr(BYTE_ALL, 20'h55400, 16'h0F0F);
        wr(BYTE_ALL, 20'h557FF, 16'hF0F0);
        rd_chk(BYTE_ALL, 20'h55400, 16'h0F0F);
        rd_chk(BYTE_ALL, 20'h557FF, 16'hF0F0);
    endtask

    task automatic t_refresh();
        logic [15:0] r0;
        r0 = refreshes;
        repeat (1000) tick();
        chk_ge(refreshes - r0, 16'h4);
        chk_data(faults, 16'h0);
    endtask

    task automatic t_reset();
        wr(BYTE_ALL, 20'h2A0F0, 16'hBEEF);
        // The write must reach the memory before reset cuts the cycle
        repeat (30) tick();
        RST_N = 1'b0;
        tick();
        tick();
        chk_data({12'h0, ROW_STROBE_N, LOWER_COL_STROBE_N, UPPER_COL_STROBE_N,
                  WRITE_STROBE_N}, 16'h000F);
        chk_data(DATA_PINS_OE, 16'h0);
        RST_N = 1'b1;
        tick();
        wait_init();
        rd_chk(BYTE_ALL, 20'h2A0F0, 16'hBEEF);
    endtask

    // Host and device must never drive the pins together
    always @(posedge CLK)
    begin
        cycles++;
        if (RST_N === 1'b1 && (DATA_PINS_OE & dq_drive) !== 16'h0)
            chk_data(DATA_PINS_OE & dq_drive, 16'h0);
        if (cycles == LIMIT)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    initial
    begin
        bad_count = 0;
        compares = 0;
        cycles = 0;
        RST_N = 1'b0;
        REQ_VALID = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_BYTE = 2'h0;
        REQ_ADDR = 20'h0;
        REQ_WDATA = 16'h0;
        repeat (8) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        t_init();
        t_words();
        t_bytes();
        t_page();
        t_refresh();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
